// file: src/vct_pkg.sv
package vct_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] VCT_OFS_START_DELAY = 8'h05;
   localparam logic [7:0] VCT_OFS_CLAMP_LEN   = 8'h06;
   localparam logic [7:0] VCT_OFS_CLAMP_SEL   = 8'h11;
   localparam int         VCT_SEL_LSB         = 4;

   // ==========================================================
   // Reset values
   localparam logic [7:0] VCT_RST_START_DELAY = 8'h08;
   localparam logic [7:0] VCT_RST_CLAMP_LEN   = 8'h14;
   localparam logic [2:0] VCT_RST_CLAMP_SEL   = 3'h0;
   localparam logic [7:0] VCT_RST_TRIM        = 8'h00;

   // ==========================================================
   // Clamp targets and trim limits
   localparam logic [7:0] VCT_CODE_GROUND     = 8'h00;
   localparam logic [7:0] VCT_CODE_MID        = 8'h80;
   localparam logic [7:0] VCT_TRIM_MAX        = 8'h7F;
   localparam logic [7:0] VCT_TRIM_MIN        = 8'h80;

   // ==========================================================
   // Serial bus device address, value is arbitrary
   localparam logic [6:0] VCT_DEV_ADDR        = 7'h2A;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {CL_IDLE, CL_WAIT, CL_ON} vct_clamp_st_t;

   typedef enum logic [3:0] {
      SB_IDLE, SB_ADDR, SB_A_ACK, SB_PTR, SB_P_ACK,
      SB_WDATA, SB_W_ACK, SB_RDATA, SB_R_ACK
   } vct_ser_st_t;

   typedef struct packed {
      logic       en;
      logic [7:0] addr;
      logic [7:0] data;
   } vct_wr_t;

   typedef struct packed {
      logic [7:0] start_delay;
      logic [7:0] clamp_len;
      logic [2:0] mid_sel;
   } vct_regs_t;

   typedef struct packed {
      vct_ser_st_t st;
      logic        scl_p;
      logic        sda_p;
      logic [7:0]  sh;
      logic [2:0]  bitc;
      logic        got8;
      logic        rw;
      logic [7:0]  ptr;
      logic        sda_o;
      logic        sda_oe;
      vct_wr_t     wr;
   } vct_ser_t;

   typedef struct packed {
      vct_regs_t        regs;
      vct_clamp_st_t    st;
      logic [7:0]       cnt;
      logic [7:0]       lim;
      logic             hs_p;
      logic             clamp;
      logic [2:0][7:0]  trim;
   } vct_core_t;

endpackage

// file: src/vct_serial_slave.sv
`timescale 1ns/10ps
module vct_serial_slave
   import vct_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Serial bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // Register access
   output vct_wr_t         wr,
   output logic [7:0]      rd_addr,
   input  wire logic [7:0] rd_data
);

   vct_ser_t s_q;
   vct_ser_t s_d;
   logic     rise;
   logic     fall;
   logic     start;
   logic     stop;

   // ==========================================================
   // Bus state machine
   always_comb begin
      s_d       = s_q;
      s_d.scl_p = scl_i;
      s_d.sda_p = sda_i;
      s_d.wr.en = 1'b0;
      rise      = scl_i & ~s_q.scl_p;
      fall      = ~scl_i & s_q.scl_p;
      start     = s_q.scl_p & scl_i & s_q.sda_p & ~sda_i;
      stop      = s_q.scl_p & scl_i & ~s_q.sda_p & sda_i;
      if (start) begin
         s_d.st     = SB_ADDR;
         s_d.bitc   = 3'h0;
         s_d.got8   = 1'b0;
         s_d.sda_oe = 1'b0;
      end else if (stop) begin
         s_d.st     = SB_IDLE;
         s_d.sda_oe = 1'b0;
      end else begin
         case (s_q.st)
            SB_ADDR, SB_PTR, SB_WDATA: begin
               if (rise) begin
                  s_d.sh   = {s_q.sh[6:0], sda_i};
                  s_d.bitc = s_q.bitc + 3'h1;
                  s_d.got8 = (s_q.bitc == 3'h7);
               end else if (fall && s_q.got8) begin
                  s_d.got8   = 1'b0;
                  s_d.sda_oe = 1'b1;
                  if (s_q.st == SB_ADDR) begin
                     // Other devices' addresses are left alone
                     if (s_q.sh[7:1] == VCT_DEV_ADDR) begin
                        s_d.rw = s_q.sh[0];
                        s_d.st = SB_A_ACK;
                     end else begin
                        s_d.sda_oe = 1'b0;
                        s_d.st     = SB_IDLE;
                     end
                  end else if (s_q.st == SB_PTR) begin
                     s_d.ptr = s_q.sh;
                     s_d.st  = SB_P_ACK;
                  end else begin
                     s_d.wr = '{en: 1'b1, addr: s_q.ptr, data: s_q.sh};
                     s_d.st = SB_W_ACK;
                  end
               end
            end
            SB_A_ACK: begin
               if (fall) begin
                  s_d.bitc = 3'h0;
                  if (s_q.rw) begin
                     s_d.sh     = rd_data;
                     s_d.sda_oe = ~rd_data[7];
                     s_d.st     = SB_RDATA;
                  end else begin
                     s_d.sda_oe = 1'b0;
                     s_d.st     = SB_PTR;
                  end
               end
            end
            SB_P_ACK, SB_W_ACK: begin
               if (fall) begin
                  s_d.sda_oe = 1'b0;
                  s_d.bitc   = 3'h0;
                  s_d.st     = SB_WDATA;
                  if (s_q.st == SB_W_ACK) begin
                     s_d.ptr = s_q.ptr + 8'h01;
                  end
               end
            end
            SB_RDATA: begin
               if (fall) begin
                  if (s_q.bitc == 3'h7) begin
                     s_d.sda_oe = 1'b0;
                     s_d.st     = SB_R_ACK;
                  end else begin
                     s_d.bitc   = s_q.bitc + 3'h1;
                     s_d.sh     = {s_q.sh[6:0], 1'b0};
                     s_d.sda_oe = ~s_q.sh[6];
                  end
               end
            end
            SB_R_ACK: begin
               if (rise) begin
                  // A missing acknowledge ends the read
                  if (sda_i) begin
                     s_d.st = SB_IDLE;
                  end else begin
                     s_d.ptr  = s_q.ptr + 8'h01;
                     s_d.got8 = 1'b1;
                  end
               end else if (fall && s_q.got8) begin
                  s_d.got8   = 1'b0;
                  s_d.bitc   = 3'h0;
                  s_d.sh     = rd_data;
                  s_d.sda_oe = ~rd_data[7];
                  s_d.st     = SB_RDATA;
               end
            end
            default: begin
               s_d.st = SB_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q       <= '0;
         s_q.st    <= SB_IDLE;
         s_q.scl_p <= 1'b1;
         s_q.sda_p <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign sda_o   = s_q.sda_o;
   assign sda_oe  = s_q.sda_oe;
   assign wr      = s_q.wr;
   assign rd_addr = s_q.ptr;

endmodule

// file: src/vct_clamp_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Clamp begins after start-delay pixel periods from the hsync trailing edge.
// - Clamp stays active for clamp-length pixel periods, then ends.
// - Start delay and clamp length are 8-bit settings, 0 to 255.
// - Timing counts pixel clock periods derived from hsync.
// - Ground-clamped channel trims offset so black converts to code zero.
// - Midscale-clamped channel trims offset toward the midscale code.
// - Three independent level select bits sit in bits 4 to 6 of one register.
module vct_clamp_top
   import vct_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // Video timing
   input  wire logic            hsync_i,
   input  wire logic            pix_ce,
   input  wire logic [2:0][7:0] adc_code,
   // Serial bus pins
   input  wire logic            scl_i,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe,
   // Clamp outputs
   output logic                 clamp_o,
   output logic [2:0]           mid_sel_o,
   output logic [2:0][7:0]      offset_trim
);

   vct_core_t  c_q;
   vct_core_t  c_d;
   vct_wr_t    wr;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   logic       hs_fall;

   // ==========================================================
   // Helpers
   function automatic logic hit(input logic [7:0] cnt, input logic [7:0] lim);
      logic [7:0] n;
      n   = cnt + 8'h01;
      hit = (n == lim);
   endfunction

   // One step toward the target, saturating at the signed limits
   function automatic logic [7:0] step(input logic [7:0] trim,
                                       input logic [7:0] code,
                                       input logic [7:0] target);
      step = trim;
      if (code > target && trim != VCT_TRIM_MIN) begin
         step = trim - 8'h01;
      end else if (code < target && trim != VCT_TRIM_MAX) begin
         step = trim + 8'h01;
      end
   endfunction

   // ==========================================================
   // Register port
   vct_serial_slave u_bus (
      .clk     (clk),
      .rst     (rst),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .sda_o   (sda_o),
      .sda_oe  (sda_oe),
      .wr      (wr),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   always_comb begin
      if (rd_addr == VCT_OFS_START_DELAY) begin
         rd_data = c_q.regs.start_delay;
      end else if (rd_addr == VCT_OFS_CLAMP_LEN) begin
         rd_data = c_q.regs.clamp_len;
      end else if (rd_addr == VCT_OFS_CLAMP_SEL) begin
         rd_data = {1'b0, c_q.regs.mid_sel, 4'h0};
      end else begin
         rd_data = 8'h00;
      end
   end

   // ==========================================================
   // Clamp timing and level loop
   assign hs_fall = c_q.hs_p & ~hsync_i;

   always_comb begin
      c_d      = c_q;
      c_d.hs_p = hsync_i;
      if (wr.en) begin
         if (wr.addr == VCT_OFS_START_DELAY) begin
            c_d.regs.start_delay = wr.data;
         end else if (wr.addr == VCT_OFS_CLAMP_LEN) begin
            c_d.regs.clamp_len = wr.data;
         end else if (wr.addr == VCT_OFS_CLAMP_SEL) begin
            c_d.regs.mid_sel = wr.data[VCT_SEL_LSB +: 3];
         end
      end
      // The edge takes priority so a long clamp never runs into the next line
      if (hs_fall) begin
         c_d.cnt = 8'h00;
         // Limits latched per phase, so a mid-line write cannot strand the count
         if (c_q.regs.start_delay != 8'h00) begin
            c_d.st    = CL_WAIT;
            c_d.lim   = c_q.regs.start_delay;
            c_d.clamp = 1'b0;
         end else if (c_q.regs.clamp_len != 8'h00) begin
            c_d.st    = CL_ON;
            c_d.lim   = c_q.regs.clamp_len;
            c_d.clamp = 1'b1;
         end else begin
            c_d.st    = CL_IDLE;
            c_d.clamp = 1'b0;
         end
      end else if (pix_ce) begin
         case (c_q.st)
            CL_WAIT: begin
               c_d.cnt = c_q.cnt + 8'h01;
               if (hit(c_q.cnt, c_q.lim)) begin
                  c_d.cnt   = 8'h00;
                  c_d.lim   = c_q.regs.clamp_len;
                  c_d.st    = (c_q.regs.clamp_len != 8'h00) ? CL_ON : CL_IDLE;
                  c_d.clamp = (c_q.regs.clamp_len != 8'h00);
               end
            end
            CL_ON: begin
               c_d.cnt = c_q.cnt + 8'h01;
               for (int i = 0; i < 3; i++) begin
                  c_d.trim[i] = step(c_q.trim[i], adc_code[i],
                     c_q.regs.mid_sel[i] ? VCT_CODE_MID : VCT_CODE_GROUND);
               end
               if (hit(c_q.cnt, c_q.lim)) begin
                  c_d.st    = CL_IDLE;
                  c_d.clamp = 1'b0;
               end
            end
            default: begin
               c_d.st = CL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         c_q                  <= '0;
         c_q.st               <= CL_IDLE;
         c_q.regs.start_delay <= VCT_RST_START_DELAY;
         c_q.regs.clamp_len   <= VCT_RST_CLAMP_LEN;
         c_q.regs.mid_sel     <= VCT_RST_CLAMP_SEL;
         c_q.trim             <= {3{VCT_RST_TRIM}};
      end else begin
         c_q <= c_d;
      end
   end

   assign clamp_o     = c_q.clamp;
   assign mid_sel_o   = c_q.regs.mid_sel;
   assign offset_trim = c_q.trim;

   // ==========================================================
   // Checks
   sequence s_edge_wait;
      hs_fall && c_q.regs.start_delay != 8'h00;
   endsequence

   sequence s_wait_done;
      !hs_fall && pix_ce && c_q.st == CL_WAIT
         && hit(c_q.cnt, c_q.lim) && c_q.regs.clamp_len != 8'h00;
   endsequence

   sequence s_on_done;
      !hs_fall && pix_ce && c_q.st == CL_ON && hit(c_q.cnt, c_q.lim);
   endsequence

   property p_edge_restart;
      @(posedge clk) disable iff (rst)
      s_edge_wait |=> c_q.st == CL_WAIT && c_q.cnt == 8'h00 && !clamp_o
         && c_q.lim == $past(c_q.regs.start_delay);
   endproperty
   a_edge_restart: assert property (p_edge_restart) else $error("edge did not restart delay");

   property p_zero_delay;
      @(posedge clk) disable iff (rst)
      hs_fall && c_q.regs.start_delay == 8'h00 && c_q.regs.clamp_len != 8'h00 |=> clamp_o;
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("zero delay did not clamp at once");

   property p_wait_to_on;
      @(posedge clk) disable iff (rst)
      s_wait_done |=> clamp_o && c_q.cnt == 8'h00 && c_q.lim == $past(c_q.regs.clamp_len);
   endproperty
   a_wait_to_on: assert property (p_wait_to_on) else $error("clamp did not start after delay");

   property p_quiet_in_wait;
      @(posedge clk) disable iff (rst)
      c_q.st == CL_WAIT |-> !clamp_o && c_q.cnt < c_q.lim;
   endproperty
   a_quiet_in_wait: assert property (p_quiet_in_wait) else $error("clamp active during delay");

   property p_len_bound;
      @(posedge clk) disable iff (rst)
      clamp_o |-> c_q.st == CL_ON && c_q.cnt < c_q.lim;
   endproperty
   a_len_bound: assert property (p_len_bound) else $error("clamp ran past its length");

   property p_on_end;
      @(posedge clk) disable iff (rst)
      s_on_done |=> !clamp_o && c_q.st == CL_IDLE;
   endproperty
   a_on_end: assert property (p_on_end) else $error("clamp did not end on length");

   property p_trim_ground;
      @(posedge clk) disable iff (rst)
      clamp_o && pix_ce && !hs_fall && !c_q.regs.mid_sel[0]
         && adc_code[0] > VCT_CODE_GROUND && c_q.trim[0] != VCT_TRIM_MIN
      |=> offset_trim[0] == $past(c_q.trim[0]) - 8'h01;
   endproperty
   a_trim_ground: assert property (p_trim_ground) else $error("ground trim not lowered");

   property p_trim_mid;
      @(posedge clk) disable iff (rst)
      clamp_o && pix_ce && !hs_fall && c_q.regs.mid_sel[1]
         && adc_code[1] < VCT_CODE_MID && c_q.trim[1] != VCT_TRIM_MAX
      |=> offset_trim[1] == $past(c_q.trim[1]) + 8'h01;
   endproperty
   a_trim_mid: assert property (p_trim_mid) else $error("midscale trim not raised");

   property p_trim_hold;
      @(posedge clk) disable iff (rst)
      !clamp_o |=> $stable(offset_trim);
   endproperty
   a_trim_hold: assert property (p_trim_hold) else $error("trim moved outside clamp");

   property p_sel_write;
      @(posedge clk) disable iff (rst)
      wr.en && wr.addr == VCT_OFS_CLAMP_SEL |=> mid_sel_o == $past(wr.data[6:4]);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("level select not stored");

endmodule

// file: testbench/vct_video_src.sv
`timescale 1ns/10ps
module vct_video_src
   import vct_pkg::*;
#(
   parameter int PIX  = 2,
   parameter int LINE = 1200,
   parameter int HS   = 40
)(
   // Clock and control
   input  wire logic       clk,
   input  wire logic       en,
   input  wire logic       early,
   // Video towards the device
   output logic            hsync,
   output logic            pix_ce,
   output logic [2:0][7:0] adc_code
);
   int cnt;

   // ==========================================
   // Line timing, sync at line end, porch after it
   initial begin
      hsync    = 1'b1;
      pix_ce   = 1'b0;
      cnt      = 0;
      adc_code = {8'h80, 8'h10, 8'h10};
   end

   always @(posedge clk) begin
      if (en && cnt >= LINE - 1) begin
         hsync  <= 1'b0;
         pix_ce <= 1'b1; // Edge-cycle pulse, device must not count it
         cnt    <= 1;
      end else begin
         pix_ce <= (cnt % PIX == 0);
         hsync  <= (cnt >= LINE - HS);
         cnt    <= early ? LINE - HS : cnt + 1; // Short line jumps straight to sync
      end
   end
endmodule

// file: testbench/test_video_clamp_timing.sv
`timescale 1ns/10ps
module test_video_clamp_timing
   import vct_pkg::*;
;
   localparam int PIX = 2;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   logic            en = 1'b0;
   logic            early = 1'b0;
   logic            scl_m = 1'b1;
   logic            sda_m = 1'b1;
   logic            hsync, pix_ce, sda_i, sda_o, sda_oe, clamp_o;
   logic [2:0][7:0] adc_code, offset_trim;
   logic [2:0]      mid_sel_o;
   logic            hs_q = 1'b1;
   int              fails = 0, checked = 0, edges = 0, t = 0, rise = -1, wid = 0;

   // ==========================================
   // Clock, open-drain wire, instances
   always #2 clk = ~clk;
   assign sda_i = sda_m & ~sda_oe;

   vct_video_src #(.PIX(PIX)) src (.clk(clk), .en(en), .early(early), .hsync(hsync),
      .pix_ce(pix_ce), .adc_code(adc_code));

   vct_clamp_top dut (.clk(clk), .rst(rst), .hsync_i(hsync), .pix_ce(pix_ce),
      .adc_code(adc_code), .scl_i(scl_m), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
      .clamp_o(clamp_o), .mid_sel_o(mid_sel_o), .offset_trim(offset_trim));

   // Clamp window measured per line, from the sync trailing edge
   always @(posedge clk) begin
      if (hs_q && !hsync) begin
         t = 0;
         rise = -1;
         wid = 0;
         edges++;
      end else begin
         t++;
         if (clamp_o === 1'b1) begin
            if (rise < 0) rise = t;
            wid++;
         end
      end
      hs_q = hsync;
   end

   // ==========================================
   // Tasks
   task automatic report_and_stop();
      if (fails == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Each pin change is held 4 clocks, slow enough for the sampled bus
   task automatic sb_line(input logic c, input logic d);
      @(posedge clk);
      scl_m <= c;
      sda_m <= d;
      repeat (3) @(posedge clk);
   endtask

   task automatic sb_start();
      sb_line(1'b0, 1'b1);
      sb_line(1'b1, 1'b1);
      sb_line(1'b1, 1'b0);
      sb_line(1'b0, 1'b0);
   endtask

   task automatic sb_stop();
      sb_line(1'b0, 1'b0);
      sb_line(1'b1, 1'b0);
      sb_line(1'b1, 1'b1);
   endtask

   // Ninth bit always released: slave ack on writes, master nack on reads
   task automatic sb_byte(input logic [7:0] b, output logic [7:0] r, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         sb_line(1'b0, i > 0 ? b[i-1] : 1'b1);
         sb_line(1'b1, i > 0 ? b[i-1] : 1'b1);
         if (i > 0) r[i-1] = sda_i;
         else ack = ~sda_i;
         sb_line(1'b0, i > 0 ? b[i-1] : 1'b1);
      end
   endtask

   task automatic sb_wr(input logic [7:0] ofs, input logic [7:0] d);
      logic [7:0] r;
      logic       a;
      sb_start();
      sb_byte({VCT_DEV_ADDR, 1'b0}, r, a);
      chk(16'(a), 16'h0001);
      sb_byte(ofs, r, a);
      chk(16'(a), 16'h0001);
      sb_byte(d, r, a);
      chk(16'(a), 16'h0001);
      sb_stop();
   endtask

   task automatic sb_rd(input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] r;
      logic       a;
      sb_start();
      sb_byte({VCT_DEV_ADDR, 1'b0}, r, a);
      sb_byte(ofs, r, a);
      sb_start();
      sb_byte({VCT_DEV_ADDR, 1'b1}, r, a);
      chk(16'(a), 16'h0001);
      sb_byte(8'hFF, r, a);
      sb_stop();
      chk(16'(r), 16'(exp));
      chk(16'(sda_o), 16'h0000);
   endtask

   // Program delay and length, then time the next full line
   task automatic measure(input logic [7:0] d, input logic [7:0] l, input bit cut);
      int e;
      sb_wr(VCT_OFS_START_DELAY, d);
      sb_wr(VCT_OFS_CLAMP_LEN, l);
      en <= 1'b1;
      e = edges;
      while (edges == e) @(posedge clk);
      if (cut) begin
         repeat (100) @(posedge clk);
         early <= 1'b1;
         @(posedge clk);
         early <= 1'b0;
         e = edges;
         while (edges == e) @(posedge clk);
      end
      repeat (1100) @(posedge clk);
      chk(16'(rise), l != 0 ? 16'(d * PIX + 1) : 16'hFFFF);
      chk(16'(wid), 16'(l * PIX));
   endtask

   // ==========================================
   // Tests
   initial begin
      logic [7:0] r;
      logic       a;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      sb_rd(VCT_OFS_START_DELAY, 8'h08);
      sb_rd(VCT_OFS_CLAMP_LEN, 8'h14);
      sb_wr(VCT_OFS_CLAMP_SEL, 8'hFF);
      sb_rd(VCT_OFS_CLAMP_SEL, 8'h70);
      sb_wr(VCT_OFS_CLAMP_SEL, 8'h60);
      chk(16'(mid_sel_o), 16'h0006);
      sb_wr(8'h07, 8'hAB);
      sb_rd(8'h07, 8'h00);
      sb_start();
      sb_byte({VCT_DEV_ADDR ^ 7'h01, 1'b0}, r, a);
      sb_stop();
      chk(16'(a), 16'h0000);
      measure(8'h08, 8'h14, 1'b0);
      chk(16'(offset_trim[0]), 16'h00EC);
      chk(16'(offset_trim[1]), 16'h0014);
      chk(16'(offset_trim[2]), 16'h0000);
      measure(8'h00, 8'h05, 1'b0);
      measure(8'h01, 8'h01, 1'b0);
      measure(8'hFF, 8'hFF, 1'b0);
      chk(16'(offset_trim[0]), 16'h0080);
      chk(16'(offset_trim[1]), 16'h007F);
      measure(8'h03, 8'h00, 1'b0);
      measure(8'h14, 8'h64, 1'b1);
      report_and_stop();
   end

   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      report_and_stop();
   end
endmodule
